// ### rtl/pmb_status_limits.sv
`timescale 1ns/1ps
// Behaviour
// [RULE1] Input over-voltage shuts the output down
// [RULE2] Restart stays armed until off, bias, clear, fault
// [RULE3] Over-voltage shutdown has no added delay
// [RULE4] Assert threshold exceeds deassert by 0.8V
// [RULE5] Power-good thresholds limited to 3.0..5.5 V
// [RULE6] Status word high byte summary bits
// [RULE7] Status word low byte fault flags
// [RULE8] Output-voltage status: bit 7 only, resettable
// [RULE9] Output-current status: bits 7, 5, resettable
// [RULE10] Input status: bits 7, 4, 3, resettable
// [RULE11] Temperature status: bits 7, 6, resettable
// [RULE12] Telemetry reads for four measured values
// [RULE13] Calibration writes locked by lock setting
// [RULE14] Input gain defaults 194, limited 180..210
// [RULE15] Input offset limited to 0..200
// [RULE16] Firmware revision byte is read-only
// [RULE17] Unimplemented flags read zero, ignore resets
module pmb_status_limits
    import pmb_pkg::*;
(
    // Clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_rstn,
    // Command port
    input  wire pmb_req_t         i_req,
    output logic                  o_ack,
    output logic                  o_nak,
    output logic [15:0]           o_rd_data,
    // Condition pins and telemetry
    input  wire logic [NPIN-1:0]  i_cond,
    input  wire pmb_tele_t        i_tele,
    input  wire logic             i_cal_lock,
    // Power stage control
    output logic                  o_output_en,
    output logic                  o_restart_armed
);

    typedef struct packed {
        logic [NPIN-1:0] s1;
        logic [NPIN-1:0] s2;
        logic [NPIN-1:0] s3;
        logic [NPIN-1:0] flt;
        logic            out_en;
        logic            armed;
        logic [7:0]      ov_resp;
        logic [15:0]     pg_on;
        logic [15:0]     pg_off;
        logic [7:0]      st_vout;
        logic [7:0]      st_iout;
        logic [7:0]      st_input;
        logic [7:0]      st_temp;
        logic            cml;
        logic [15:0]     vout_gain;
        logic [15:0]     vout_ofs;
        logic [15:0]     vin_gain;
        logic [15:0]     vin_ofs;
        pmb_rsp_t        rsp;
    } state_t;

    localparam state_t STATE_RESET = '{
        s1:        '0,
        s2:        '0,
        s3:        '0,
        flt:       '0,
        out_en:    1'b0,
        armed:     1'b0,
        ov_resp:   OV_RESP_RESET,
        pg_on:     PG_ASSERT_RESET,
        pg_off:    PG_DEASSERT_RESET,
        st_vout:   8'h00,
        st_iout:   8'h00,
        st_input:  8'h00,
        st_temp:   8'h00,
        cml:       1'b0,
        vout_gain: VOUT_GAIN_RESET,
        vout_ofs:  VOUT_OFS_RESET,
        vin_gain:  VIN_GAIN_RESET,
        vin_ofs:   VIN_OFS_RESET,
        rsp:       '0
    };

    logic [1:0] rst_sync_ff;
    logic       rst_n;
    state_t     state_ff;
    state_t     nxt_state;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    logic [15:0] status_word;
    logic        wr_ok;
    logic        known;
    logic [15:0] rdata;
    logic        ov_trip;
    logic        run_ok;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.s1 = i_cond;
        nxt_state.s2 = state_ff.s1;
        nxt_state.s3 = state_ff.s2;
        // A pin change counts only once two stages agree
        for (int i = 0; i < NPIN; i++) begin
            if (state_ff.s2[i] == state_ff.s3[i]) begin
                nxt_state.flt[i] = state_ff.s2[i];
            end
        end

        // Reaction field is read-only at shutdown, so an over-voltage
        // always drops the output
        ov_trip = state_ff.flt[PIN_VIN_OV];
        run_ok  = state_ff.flt[PIN_ON_CMD] && state_ff.flt[PIN_BIAS_OK]
                  && !state_ff.flt[PIN_OTHER_FLT];
        nxt_state.out_en = run_ok && !ov_trip && !state_ff.flt[PIN_VOUT_OV]
                           && !state_ff.flt[PIN_IOUT_OC]
                           && !state_ff.flt[PIN_OT_FAULT]; // [RULE1] [RULE3]

        if (!run_ok || !ov_trip) begin
            nxt_state.armed = 1'b0; // [RULE2]
        end else if (state_ff.out_en) begin
            nxt_state.armed = 1'b1; // [RULE2]
        end

        status_word = 16'h0000;
        status_word[SW_VOUT]  = |state_ff.st_vout; // [RULE6]
        status_word[SW_IPOUT] = |state_ff.st_iout;
        status_word[SW_INPUT] = |state_ff.st_input;
        status_word[SW_NPG]   = !state_ff.flt[PIN_PGOOD];
        status_word[SW_OFF]   = !state_ff.out_en; // [RULE7]
        status_word[SW_VOV]   = state_ff.st_vout[ST_B7];
        status_word[SW_IOC]   = state_ff.st_iout[ST_B7];
        status_word[SW_VINUV] = state_ff.st_input[ST_B4];
        status_word[SW_TEMP]  = |state_ff.st_temp;
        status_word[SW_CML]   = state_ff.cml;

        wr_ok = 1'b0;
        known = 1'b1;
        rdata = 16'h0000;
        case (i_req.code)
            CMD_VIN_OV_RESP: begin
                rdata = {8'h00, state_ff.ov_resp};
                wr_ok = i_req.data[RESTART_LSB +: 3] == RESTART_NEVER
                        || i_req.data[RESTART_LSB +: 3] == RESTART_ALWAYS;
            end
            CMD_PG_ASSERT: begin
                rdata = state_ff.pg_on;
                wr_ok = i_req.data >= PG_MIN && i_req.data <= PG_MAX
                        && i_req.data >= state_ff.pg_off + PG_GAP; // [RULE4] [RULE5]
            end
            CMD_PG_DEASSERT: begin
                rdata = state_ff.pg_off;
                wr_ok = i_req.data >= PG_MIN && i_req.data <= PG_MAX
                        && i_req.data + PG_GAP <= state_ff.pg_on; // [RULE4] [RULE5]
            end
            CMD_STATUS_WORD: begin
                rdata = status_word;
                wr_ok = 1'b1;
            end
            CMD_STATUS_VOUT: begin
                rdata = {8'h00, state_ff.st_vout};
                wr_ok = 1'b1;
            end
            CMD_OUTPUT_CURRENT_STATUS: begin
                rdata = {8'h00, state_ff.st_iout};
                wr_ok = 1'b1;
            end
            CMD_STATUS_INPUT: begin
                rdata = {8'h00, state_ff.st_input};
                wr_ok = 1'b1;
            end
            CMD_STATUS_TEMP: begin
                rdata = {8'h00, state_ff.st_temp};
                wr_ok = 1'b1;
            end
            CMD_INPUT_VOLTAGE_READING:  rdata = i_tele.vin; // [RULE12]
            CMD_READ_VOUT: rdata = i_tele.vout; // [RULE12]
            CMD_OUTPUT_CURRENT_READING: rdata = i_tele.iout; // [RULE12]
            CMD_READ_TEMP: rdata = i_tele.temp; // [RULE12]
            CMD_FW_REV:    rdata = {8'h00, FW_REV_VALUE}; // [RULE16]
            CMD_VOUT_GAIN: begin
                rdata = state_ff.vout_gain;
                wr_ok = !i_cal_lock; // [RULE13]
            end
            CMD_VOUT_OFFSET: begin
                rdata = state_ff.vout_ofs;
                wr_ok = !i_cal_lock; // [RULE13]
            end
            CMD_VIN_GAIN: begin
                rdata = state_ff.vin_gain;
                wr_ok = !i_cal_lock && i_req.data >= VIN_GAIN_MIN
                        && i_req.data <= VIN_GAIN_MAX; // [RULE13] [RULE14]
            end
            CMD_VIN_OFFSET: begin
                rdata = state_ff.vin_ofs;
                wr_ok = !i_cal_lock && i_req.data <= VIN_OFS_MAX; // [RULE15]
            end
            default: known = 1'b0;
        endcase

        nxt_state.rsp = '0;
        if (i_req.rd) begin
            nxt_state.rsp.ack  = known;
            nxt_state.rsp.nak  = !known;
            nxt_state.rsp.data = rdata;
        end else if (i_req.wr) begin
            nxt_state.rsp.ack = wr_ok;
            nxt_state.rsp.nak = !wr_ok;
        end

        // Writes apply first; hardware sets below then win over clears
        if (i_req.wr && wr_ok) begin
            case (i_req.code)
                CMD_VIN_OV_RESP: nxt_state.ov_resp = (state_ff.ov_resp
                    & ~OV_RESP_WR_MASK) | (i_req.data[7:0] & OV_RESP_WR_MASK);
                CMD_PG_ASSERT:   nxt_state.pg_on = i_req.data;
                CMD_PG_DEASSERT: nxt_state.pg_off = i_req.data;
                CMD_STATUS_WORD: begin
                    if (i_req.data[SW_CML]) begin
                        nxt_state.cml = 1'b0;
                    end
                end
                CMD_STATUS_VOUT:  nxt_state.st_vout =
                    state_ff.st_vout & ~i_req.data[7:0]; // [RULE8]
                CMD_OUTPUT_CURRENT_STATUS:  nxt_state.st_iout =
                    state_ff.st_iout & ~i_req.data[7:0]; // [RULE9]
                CMD_STATUS_INPUT: nxt_state.st_input =
                    state_ff.st_input & ~i_req.data[7:0]; // [RULE10]
                CMD_STATUS_TEMP:  nxt_state.st_temp =
                    state_ff.st_temp & ~i_req.data[7:0]; // [RULE11]
                CMD_VOUT_GAIN:   nxt_state.vout_gain = i_req.data;
                CMD_VOUT_OFFSET: nxt_state.vout_ofs = i_req.data;
                CMD_VIN_GAIN:    nxt_state.vin_gain = i_req.data;
                CMD_VIN_OFFSET:  nxt_state.vin_ofs = i_req.data;
                default: ;
            endcase
        end
        if ((i_req.wr && !wr_ok) || (i_req.rd && !known)) begin
            nxt_state.cml = 1'b1;
        end

        if (state_ff.flt[PIN_VOUT_OV]) begin
            nxt_state.st_vout[ST_B7] = 1'b1; // [RULE8]
        end
        if (state_ff.flt[PIN_IOUT_OC]) begin
            nxt_state.st_iout[ST_B7] = 1'b1; // [RULE9]
        end
        if (state_ff.flt[PIN_IOUT_WARN]) begin
            nxt_state.st_iout[ST_B5] = 1'b1; // [RULE9]
        end
        if (state_ff.flt[PIN_VIN_OV]) begin
            nxt_state.st_input[ST_B7] = 1'b1; // [RULE10]
        end
        if (state_ff.flt[PIN_VIN_UV]) begin
            nxt_state.st_input[ST_B4] = 1'b1; // [RULE10]
        end
        if (state_ff.flt[PIN_VIN_UV] && !state_ff.out_en) begin
            nxt_state.st_input[ST_B3] = 1'b1; // [RULE10]
        end
        if (state_ff.flt[PIN_OT_FAULT]) begin
            nxt_state.st_temp[ST_B7] = 1'b1; // [RULE11]
        end
        if (state_ff.flt[PIN_OT_WARN]) begin
            nxt_state.st_temp[ST_B6] = 1'b1; // [RULE11]
        end

        // Unimplemented bits never hold a one
        nxt_state.st_vout  = nxt_state.st_vout & VOUT_ST_MASK; // [RULE17]
        nxt_state.st_iout  = nxt_state.st_iout & IOUT_ST_MASK; // [RULE17]
        nxt_state.st_input = nxt_state.st_input & INPUT_ST_MASK; // [RULE17]
        nxt_state.st_temp  = nxt_state.st_temp & TEMP_ST_MASK; // [RULE17]
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= STATE_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_ack           = state_ff.rsp.ack;
    assign o_nak           = state_ff.rsp.nak;
    assign o_rd_data       = state_ff.rsp.data;
    assign o_output_en     = state_ff.out_en;
    assign o_restart_armed = state_ff.armed;

    a_ov_shutdown: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RULE1]
        state_ff.flt[PIN_VIN_OV] |=> !o_output_en)
        else $error("output stayed on during input over-voltage");

    a_ov_no_delay: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RULE3]
        $rose(state_ff.flt[PIN_VIN_OV]) && o_output_en |=> !o_output_en)
        else $error("over-voltage shutdown delayed");

    a_restart_drop: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RULE2]
        o_restart_armed && !state_ff.flt[PIN_ON_CMD] |=> !o_restart_armed)
        else $error("restart stayed armed after command off");

    a_restart_arm: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RULE2]
        o_output_en && state_ff.flt[PIN_VIN_OV] && run_ok
        |=> o_restart_armed)
        else $error("restart not armed after over-voltage shutdown");

    a_pg_gap: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RULE4]
        state_ff.pg_on >= state_ff.pg_off + PG_GAP)
        else $error("power-good hysteresis gap broken");

    a_pg_range: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RULE5]
        state_ff.pg_on <= PG_MAX && state_ff.pg_off >= PG_MIN)
        else $error("power-good threshold out of range");

    a_sw_input_sum: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RULE6]
        i_req.rd && i_req.code == CMD_STATUS_WORD
        |=> o_rd_data[SW_INPUT] == |$past(state_ff.st_input))
        else $error("input summary bit wrong");

    a_sw_off_bit: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RULE7]
        i_req.rd && i_req.code == CMD_STATUS_WORD
        |=> o_rd_data[SW_OFF] == !$past(o_output_en))
        else $error("output-off bit wrong");

    a_set_wins: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RULE10]
        state_ff.flt[PIN_VIN_OV] |=> state_ff.st_input[ST_B7])
        else $error("input over-voltage flag lost");

    a_unimpl_zero: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RULE17]
        (state_ff.st_vout & ~VOUT_ST_MASK) == 8'h00
        && (state_ff.st_temp & ~TEMP_ST_MASK) == 8'h00)
        else $error("unimplemented status bit set");

    a_cal_lock: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RULE13]
        i_req.wr && !i_req.rd && i_cal_lock && i_req.code == CMD_VOUT_GAIN
        |=> o_nak && $stable(state_ff.vout_gain))
        else $error("calibration write passed the lock");

    a_vin_gain_rng: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RULE14]
        state_ff.vin_gain >= VIN_GAIN_MIN && state_ff.vin_gain <= VIN_GAIN_MAX)
        else $error("input gain out of range");

    a_vin_ofs_rng: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RULE15]
        state_ff.vin_ofs <= VIN_OFS_MAX)
        else $error("input offset out of range");

    a_fw_ro: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RULE16]
        i_req.wr && !i_req.rd && i_req.code == CMD_FW_REV |=> o_nak)
        else $error("firmware revision write accepted");

endmodule

// ### pkg/pmb_pkg.sv
package pmb_pkg;

    // Command codes
    localparam logic [7:0] CMD_VIN_OV_RESP  = 8'h56;
    localparam logic [7:0] CMD_PG_ASSERT    = 8'h5E;
    localparam logic [7:0] CMD_PG_DEASSERT  = 8'h5F;
    localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;
    localparam logic [7:0] CMD_STATUS_VOUT  = 8'h7A;
    localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS  = 8'h7B;
    localparam logic [7:0] CMD_STATUS_INPUT = 8'h7C;
    localparam logic [7:0] CMD_STATUS_TEMP  = 8'h7D;
    localparam logic [7:0] CMD_INPUT_VOLTAGE_READING     = 8'h88;
    localparam logic [7:0] CMD_READ_VOUT    = 8'h8B;
    localparam logic [7:0] CMD_OUTPUT_CURRENT_READING    = 8'h8C;
    localparam logic [7:0] CMD_READ_TEMP    = 8'h8D;
    localparam logic [7:0] CMD_FW_REV       = 8'h9B;
    localparam logic [7:0] CMD_VOUT_GAIN    = 8'hD1;
    localparam logic [7:0] CMD_VOUT_OFFSET  = 8'hD2;
    localparam logic [7:0] CMD_VIN_GAIN     = 8'hDD;
    localparam logic [7:0] CMD_VIN_OFFSET   = 8'hDE;

    // Fault response byte: reaction and delay fields fixed, retry writable
    localparam logic [7:0] OV_RESP_RESET    = 8'hC0;
    localparam logic [7:0] OV_RESP_WR_MASK  = 8'h38;
    localparam int         RESTART_LSB      = 3;
    localparam logic [2:0] RESTART_NEVER    = 3'h0;
    localparam logic [2:0] RESTART_ALWAYS   = 3'h7;

    // Power-good thresholds, volts scaled by 2^9
    localparam int          PG_LSB_PER_VOLT = 512;
    localparam real         PG_MIN_V        = 3.0;
    localparam real         PG_MAX_V        = 5.5;
    localparam real         PG_GAP_V        = 0.8;
    localparam logic [15:0] PG_MIN   = 16'(int'(PG_MIN_V * PG_LSB_PER_VOLT));
    localparam logic [15:0] PG_MAX   = 16'(int'(PG_MAX_V * PG_LSB_PER_VOLT));
    localparam logic [15:0] PG_GAP   = 16'h019A;
    localparam logic [15:0] PG_ASSERT_RESET   = 16'h0900;
    localparam logic [15:0] PG_DEASSERT_RESET = 16'h0700;

    // Calibration factors
    localparam logic [15:0] VIN_GAIN_RESET  = 16'h00C2;
    localparam logic [15:0] VIN_GAIN_MIN    = 16'h00B4;
    localparam logic [15:0] VIN_GAIN_MAX    = 16'h00D2;
    localparam logic [15:0] VIN_OFS_RESET   = 16'h0000;
    localparam logic [15:0] VIN_OFS_MAX     = 16'h00C8;
    localparam logic [15:0] VOUT_GAIN_RESET = 16'h0000;
    localparam logic [15:0] VOUT_OFS_RESET  = 16'h0000;

    // Value is arbitrary
    localparam logic [7:0]  FW_REV_VALUE    = 8'h10;

    // Status bit positions
    localparam int SW_VOUT   = 15;
    localparam int SW_IPOUT  = 14;
    localparam int SW_INPUT  = 13;
    localparam int SW_NPG    = 11;
    localparam int SW_OFF    = 6;
    localparam int SW_VOV    = 5;
    localparam int SW_IOC    = 4;
    localparam int SW_VINUV  = 3;
    localparam int SW_TEMP   = 2;
    localparam int SW_CML    = 1;
    localparam int ST_B7     = 7;
    localparam int ST_B6     = 6;
    localparam int ST_B5     = 5;
    localparam int ST_B4     = 4;
    localparam int ST_B3     = 3;
    localparam logic [7:0] VOUT_ST_MASK  = 8'h80;
    localparam logic [7:0] IOUT_ST_MASK  = 8'hA0;
    localparam logic [7:0] INPUT_ST_MASK = 8'h98;
    localparam logic [7:0] TEMP_ST_MASK  = 8'hC0;

    // Condition pins
    localparam int NPIN          = 11;
    localparam int PIN_VIN_OV    = 0;
    localparam int PIN_VIN_UV    = 1;
    localparam int PIN_VOUT_OV   = 2;
    localparam int PIN_IOUT_OC   = 3;
    localparam int PIN_IOUT_WARN = 4;
    localparam int PIN_OT_FAULT  = 5;
    localparam int PIN_OT_WARN   = 6;
    localparam int PIN_PGOOD     = 7;
    localparam int PIN_BIAS_OK   = 8;
    localparam int PIN_ON_CMD    = 9;
    localparam int PIN_OTHER_FLT = 10;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  code;
        logic [15:0] data;
    } pmb_req_t;

    typedef struct packed {
        logic        ack;
        logic        nak;
        logic [15:0] data;
    } pmb_rsp_t;

    typedef struct packed {
        logic [15:0] vin;
        logic [15:0] vout;
        logic [15:0] iout;
        logic [15:0] temp;
    } pmb_tele_t;

endpackage

// ### verif/pmb_host_model.sv
`timescale 1ns/1ps
module pmb_host_model
    import pmb_pkg::*;
(
    // Clock
    input  wire logic        i_clk_sys,
    // Command port toward the device
    output pmb_req_t         o_req,
    input  wire logic        i_ack,
    input  wire logic        i_nak,
    input  wire logic [15:0] i_rd_data
);
    logic        got_ack;
    logic        got_nak;
    logic [15:0] got_data;

    initial o_req = '0;

    // Released code and data go inverted so nothing stale looks valid
    task automatic xfer(input logic r, input logic [7:0] c,
                        input logic [15:0] d);
        @(posedge i_clk_sys);
        o_req <= '{rd: r, wr: !r, code: c, data: d};
        @(posedge i_clk_sys);
        o_req <= '{rd: 1'b0, wr: 1'b0, code: ~c, data: ~d};
        #1;
        got_ack  = i_ack;
        got_nak  = i_nak;
        got_data = i_rd_data;
    endtask
endmodule

// ### verif/pmbus_status_limit_commands_bench.sv
`timescale 1ns/1ps
module pmbus_status_limit_commands_bench
    import pmb_pkg::*;
;
    localparam logic [10:0] BASE = 11'h380;
    logic            i_clk_sys = 1'b0;
    logic            i_rstn;
    logic            i_cal_lock;
    logic [NPIN-1:0] i_cond;
    pmb_tele_t       i_tele;
    pmb_req_t        req;
    logic            o_ack;
    logic            o_nak;
    logic [15:0]     o_rd_data;
    logic            o_output_en;
    logic            o_restart_armed;
    int              n_fail;
    int              samples_checked;
    logic            lock;
    logic [7:0]      c;
    logic [15:0]     d;
    logic [15:0]     shadow [logic [7:0]];
    logic [7:0]      codes [7] = '{CMD_VIN_OV_RESP, CMD_PG_ASSERT,
        CMD_PG_DEASSERT, CMD_VOUT_GAIN, CMD_VOUT_OFFSET, CMD_VIN_GAIN,
        CMD_VIN_OFFSET};
    logic [7:0]      st_c [8] = '{8'h7C, 8'h7C, 8'h7A, 8'h7B, 8'h7B,
        8'h7D, 8'h7D, 8'h7A};
    logic [7:0]      st_b [8] = '{8'h80, 8'h10, 8'h80, 8'h80, 8'h20,
        8'h80, 8'h40, 8'h00};
    logic [15:0]     st_w [8] = '{16'h2040, 16'h2008, 16'h8060, 16'h4050,
        16'h4000, 16'h0044, 16'h0004, 16'h0800};
    logic [7:0]      shut = 8'h2D;
    int              stop [4] = '{0, 9, 8, 10};

    always #12.5 i_clk_sys = ~i_clk_sys;

    pmb_status_limits DUT (
        .i_clk_sys       (i_clk_sys),
        .i_rstn          (i_rstn),
        .i_req           (req),
        .o_ack           (o_ack),
        .o_nak           (o_nak),
        .o_rd_data       (o_rd_data),
        .i_cond          (i_cond),
        .i_tele          (i_tele),
        .i_cal_lock      (i_cal_lock),
        .o_output_en     (o_output_en),
        .o_restart_armed (o_restart_armed)
    );

    pmb_host_model u_host (
        .i_clk_sys (i_clk_sys),
        .o_req     (req),
        .i_ack     (o_ack),
        .i_nak     (o_nak),
        .i_rd_data (o_rd_data)
    );

    task automatic check(input string what, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic xchk(input logic r, input logic [7:0] k,
                        input logic [15:0] v, input logic ok);
        u_host.xfer(r, k, v);
        check($sformatf("resp %h", k),
              {14'h0, u_host.got_ack, u_host.got_nak}, ok ? 16'h2 : 16'h1);
    endtask

    task automatic rdm(input logic [7:0] k, input logic [15:0] m, e);
        xchk(1'b1, k, 16'h0000, 1'b1);
        check($sformatf("cmd %h", k), u_host.got_data & m, e);
    endtask

    // Acceptance worked out from limits, gap and lock
    function automatic logic accept(input logic [7:0] k, input logic [15:0] v);
        case (k)
            CMD_VIN_OV_RESP: return v[5:3] == 3'h0 || v[5:3] == 3'h7;
            CMD_PG_ASSERT: return v >= PG_MIN && v <= PG_MAX &&
                v >= shadow[CMD_PG_DEASSERT] + PG_GAP;
            CMD_PG_DEASSERT: return v >= PG_MIN && v <= PG_MAX &&
                shadow[CMD_PG_ASSERT] >= v + PG_GAP;
            CMD_VOUT_GAIN, CMD_VOUT_OFFSET: return !lock;
            CMD_VIN_GAIN: return !lock && v >= 16'h00B4 && v <= 16'h00D2;
            CMD_VIN_OFFSET: return !lock && v <= 16'h00C8;
            default: return 1'b0;
        endcase
    endfunction

    task automatic wr_reg(input logic [7:0] k, input logic [15:0] v);
        logic ok;
        ok = accept(k, v);
        xchk(1'b0, k, v, ok);
        if (ok) begin
            shadow[k] = (k == CMD_VIN_OV_RESP) ? (16'h00C0 | (v & 16'h0038)) : v;
        end
        rdm(k, 16'hFFFF, shadow[k]);
    endtask

    initial begin
        #(25 * 40000);
        n_fail++;
        test_done();
    end

    initial begin
        n_fail = 0;
        samples_checked = 0;
        i_rstn = 1'b0;
        i_cal_lock = 1'b0;
        lock = 1'b0;
        i_cond = '0;
        i_tele = '0;
        shadow = '{8'h56: 16'h00C0, 8'h5E: 16'h0900, 8'h5F: 16'h0700,
                   8'hD1: 16'h0000, 8'hD2: 16'h0000, 8'hDD: 16'h00C2,
                   8'hDE: 16'h0000};
        void'($urandom(91514));
        repeat (5) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        i_cond <= BASE;
        for (int k = 0; k < 7; k++) begin
            rdm(codes[k], 16'hFFFF, shadow[codes[k]]);
        end
        rdm(CMD_FW_REV, 16'hFFFF, {8'h00, FW_REV_VALUE});
        xchk(1'b0, CMD_FW_REV, 16'h0055, 1'b0);
        xchk(1'b0, CMD_INPUT_VOLTAGE_READING, 16'h0055, 1'b0);
        xchk(1'b1, 8'h00, 16'h0000, 1'b0);
        rdm(CMD_STATUS_WORD, 16'h0002, 16'h0002);
        xchk(1'b0, CMD_STATUS_WORD, 16'h0002, 1'b1);
        rdm(CMD_STATUS_WORD, 16'h0002, 16'h0000);
        wr_reg(8'h5F, 16'h0680);
        wr_reg(8'h5E, 16'h0819);
        wr_reg(8'h5E, 16'h081A);
        wr_reg(8'h5E, 16'h0B01);
        wr_reg(8'h5E, 16'h0B00);
        wr_reg(8'h5F, 16'h05FF);
        wr_reg(8'h56, 16'h0038);
        wr_reg(8'h56, 16'h0010);
        wr_reg(8'hDD, 16'h00B3);
        wr_reg(8'hDD, 16'h00B4);
        wr_reg(8'hDD, 16'h00D3);
        wr_reg(8'hDD, 16'h00D2);
        wr_reg(8'hDE, 16'h00C9);
        wr_reg(8'hDE, 16'h00C8);
        for (int k = 0; k < 40; k++) begin
            c = codes[$urandom % 7];
            lock = ($urandom % 4) == 0;
            d = 16'($urandom);
            if (c == CMD_VIN_OV_RESP) d = d & 16'h00FF;
            if (c == CMD_PG_ASSERT || c == CMD_PG_DEASSERT) begin
                d = 16'h0500 + d % 16'h0700;
            end
            if (c == CMD_VIN_GAIN || c == CMD_VIN_OFFSET) d = d % 16'h0100;
            @(posedge i_clk_sys);
            i_cal_lock <= lock;
            wr_reg(c, d);
        end
        lock = 1'b0;
        @(posedge i_clk_sys);
        i_cal_lock <= 1'b0;
        i_tele <= {16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom)};
        @(posedge i_clk_sys);
        rdm(CMD_INPUT_VOLTAGE_READING, 16'hFFFF, i_tele.vin);
        rdm(CMD_READ_VOUT, 16'hFFFF, i_tele.vout);
        rdm(CMD_OUTPUT_CURRENT_READING, 16'hFFFF, i_tele.iout);
        rdm(CMD_READ_TEMP, 16'hFFFF, i_tele.temp);
        for (int k = 0; k < 8; k++) begin
            @(posedge i_clk_sys);
            i_cond <= BASE ^ (11'h001 << k);
            repeat (5) @(posedge i_clk_sys);
            #1;
            check("output enable", {15'h0, o_output_en},
                  {15'h0, !shut[k]});
            rdm(st_c[k], 16'hFFFF, {8'h00, st_b[k]});
            rdm(CMD_STATUS_WORD, 16'hFFFD, st_w[k]);
            xchk(1'b0, st_c[k], 16'h00FF, 1'b1);
            rdm(st_c[k], 16'hFFFF, {8'h00, st_b[k]});
            @(posedge i_clk_sys);
            i_cond <= BASE;
            repeat (8) @(posedge i_clk_sys);
            xchk(1'b0, st_c[k], 16'h00FF, 1'b1);
            rdm(st_c[k], 16'hFFFF, 16'h0000);
        end
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clk_sys);
            i_cond <= BASE | 11'h001;
            repeat (6) @(posedge i_clk_sys);
            #1;
            check("armed", {15'h0, o_restart_armed}, 16'h0001);
            @(posedge i_clk_sys);
            i_cond <= (BASE | 11'h001) ^ (11'h001 << stop[k]);
            repeat (6) @(posedge i_clk_sys);
            #1;
            check("disarmed", {15'h0, o_restart_armed},
                  16'h0000);
            @(posedge i_clk_sys);
            i_cond <= BASE;
            repeat (8) @(posedge i_clk_sys);
            xchk(1'b0, CMD_STATUS_INPUT, 16'h00FF, 1'b1);
        end
        test_done();
    end
endmodule
